// ---- logic/brc_pkg.sv ----
package brc_pkg;
   // register byte addresses on the management serial bus
   localparam logic [7:0] ADDR_DEFER = 8'h10;
   localparam logic [7:0] ADDR_CTL0 = 8'h53;
   localparam logic [7:0] ADDR_CTL1 = 8'h54;
   localparam logic [7:0] ADDR_RAMP0 = 8'ha8;
   localparam logic [7:0] ADDR_RAMP1 = 8'ha9;
   localparam logic [7:0] ADDR_VCODE0 = 8'hbe;
   localparam logic [7:0] ADDR_VCODE1 = 8'hce;
   localparam logic [7:0] ADDR_GRP0 = 8'he6;
   localparam logic [7:0] ADDR_GRP1 = 8'he7;

   // reset values
   localparam logic [7:0] RST_VCODE = 8'h97;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // field positions
   localparam int CTL_LINK_BIT = 4;
   localparam int CTL_SEL_BIT = 1;
   localparam int CTL_CMD_BIT = 0;
   localparam int RAMP_FAST_LO = 4;
   localparam int RAMP_SLOW_BIT = 0;
   localparam int GRP_TYPE_LO = 4;
   localparam int GRP_DELAY_LO = 0;

   // writable bit masks; reserved bits read zero
   localparam logic [7:0] MASK_CTL = 8'h13;
   localparam logic [7:0] MASK_RAMP = 8'h31;
   localparam logic [7:0] MASK_GRP = 8'h3f;
   localparam logic [7:0] MASK_DEFER = 8'h03;

   localparam logic [1:0] FAST_RESERVED = 2'h3;
   localparam logic [3:0] GROUP_DISABLE = 4'hf;

   typedef enum logic [1:0] {
      BRC_TYPE_A,
      BRC_TYPE_U,
      BRC_TYPE_S,
      BRC_TYPE_SX
   } brc_type_t;

   function automatic logic [7:0] brc_masked(input logic [7:0] d,
                                             input logic [7:0] m);
      return d & m;
   endfunction
endpackage

// ---- logic/brc_sync.sv ----
module brc_sync
   import brc_pkg::*;
#(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // a change is taken only once the second and third stage agree
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
         o_level <= RESET_VAL;
      end else if (i_ce) begin
         s1_r <= i_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            o_level <= s3_r;
         end
      end
   end
endmodule // brc_sync

// ---- logic/brc_regs.sv ----
// Function
// RQ1: each rail keeps an 8-bit voltage code, reset 0x97
// RQ2: control bit 4 enables the serial voltage id link, fuse default
// RQ3: select bit clear: rail follows the power sequencer
// RQ4: select bit set: rail follows software command bit 0
// RQ5: fast ramp bits 5:4 pick fast slew, 11 reserved, reset 00
// RQ6: slow ramp bit 0 picks slow slew, reset 0
// RQ7: sequencing bits 5:4 hold rail type A/U/S/SX, fuse default
// RQ8: sequencing bits 3:0 hold delay group, 1111 removes rail
// RQ9: deferred-type register holds enables in bits 1 and 0, reset 0
// RQ10: deferred off: rail uses its own sequencing register type
// RQ11: deferred on: rail starts as type A, keeps its group delay
// RQ12: stays type A until both reset inputs are low together
// RQ13: after that the programmed type is used until system reset
// RQ14: reset inputs synchronised; both low same cycle latches switch
module brc_regs
   import brc_pkg::*;
#(
   parameter int NUM_RAILS = 2,
   parameter logic [NUM_RAILS-1:0] FUSE_LINK_EN = '1,
   parameter logic [5:0] FUSE_GRP0 = 6'h00,
   parameter logic [5:0] FUSE_GRP1 = 6'h01
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // register port of the serial bus engine
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rd_valid,
   output logic o_addr_hit,
   // power sequencer on/off request per rail
   input wire logic [1:0] i_seq_on,
   // platform resets from pins, active low
   input wire logic i_resume_reset_n,
   input wire logic i_platform_reset_n,
   // to the regulators and the sequencer
   output logic [7:0] o_voltage_code_0,
   output logic [7:0] o_voltage_code_1,
   output logic [1:0] o_rail_on,
   output logic [1:0] o_link_en,
   output logic [1:0] o_fast_ramp_0,
   output logic [1:0] o_fast_ramp_1,
   output logic [1:0] o_slow_ramp,
   output logic [1:0] o_fast_ramp_bad,
   output logic [1:0] o_rail_type_0,
   output logic [1:0] o_rail_type_1,
   output logic [3:0] o_group_delay_0,
   output logic [3:0] o_group_delay_1,
   output logic [1:0] o_seq_excluded,
   output logic [1:0] o_type_released
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] vcode0_r;
   logic [7:0] vcode1_r;
   logic [7:0] ctl0_r;
   logic [7:0] ctl1_r;
   logic [7:0] ramp0_r;
   logic [7:0] ramp1_r;
   logic [7:0] grp0_r;
   logic [7:0] grp1_r;
   logic [7:0] defer_r;
   logic released_r;
   logic [7:0] rdata_nxt;
   logic hit_nxt;

   wire logic [7:0] wmask_ctl = brc_masked(i_wdata, MASK_CTL);
   wire logic [7:0] wmask_ramp = brc_masked(i_wdata, MASK_RAMP);
   wire logic [7:0] wmask_grp = brc_masked(i_wdata, MASK_GRP);
   wire logic [7:0] wmask_defer = brc_masked(i_wdata, MASK_DEFER);

   wire logic wr_vcode0 = i_wr_en && (i_addr == ADDR_VCODE0);
   wire logic wr_vcode1 = i_wr_en && (i_addr == ADDR_VCODE1);
   wire logic wr_ctl0 = i_wr_en && (i_addr == ADDR_CTL0);
   wire logic wr_ctl1 = i_wr_en && (i_addr == ADDR_CTL1);
   wire logic wr_ramp0 = i_wr_en && (i_addr == ADDR_RAMP0);
   wire logic wr_ramp1 = i_wr_en && (i_addr == ADDR_RAMP1);
   wire logic wr_grp0 = i_wr_en && (i_addr == ADDR_GRP0);
   wire logic wr_grp1 = i_wr_en && (i_addr == ADDR_GRP1);
   wire logic wr_defer = i_wr_en && (i_addr == ADDR_DEFER);

   wire logic [7:0] ctl_rst0 = {3'h0, FUSE_LINK_EN[0], 4'h0};
   wire logic [7:0] ctl_rst1 = {3'h0, FUSE_LINK_EN[1], 4'h0};

   // ------------------------------------------------------------
   // register write
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         vcode0_r <= RST_VCODE; // [RQ1]
         vcode1_r <= RST_VCODE; // [RQ1]
         ctl0_r <= RST_ZERO;
         ctl1_r <= RST_ZERO;
         ramp0_r <= RST_ZERO; // [RQ5] [RQ6]
         ramp1_r <= RST_ZERO; // [RQ5] [RQ6]
         grp0_r <= RST_ZERO;
         grp1_r <= RST_ZERO;
         defer_r <= RST_ZERO; // [RQ9]
      end else if (i_ce) begin
         if (wr_vcode0) vcode0_r <= i_wdata; // [RQ1]
         if (wr_vcode1) vcode1_r <= i_wdata; // [RQ1]
         if (wr_ctl0) ctl0_r <= wmask_ctl; // [RQ2]
         if (wr_ctl1) ctl1_r <= wmask_ctl; // [RQ2]
         if (wr_ramp0) ramp0_r <= wmask_ramp; // [RQ5] [RQ6]
         if (wr_ramp1) ramp1_r <= wmask_ramp; // [RQ5] [RQ6]
         if (wr_grp0) grp0_r <= wmask_grp; // [RQ7] [RQ8]
         if (wr_grp1) grp1_r <= wmask_grp; // [RQ7] [RQ8]
         if (wr_defer) defer_r <= wmask_defer; // [RQ9]
      end
   end

   // fuse defaults are not port constants at reset: load them at the
   // second enabled cycle after release, unless software writes first
   logic fuse_loaded_r;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fuse_loaded_r <= 1'b0;
      end else if (i_ce) begin
         fuse_loaded_r <= 1'b1;
      end
   end

   logic [7:0] ctl0_q;
   logic [7:0] ctl1_q;
   logic [7:0] grp0_q;
   logic [7:0] grp1_q;
   logic ctl0_w_r;
   logic ctl1_w_r;
   logic grp0_w_r;
   logic grp1_w_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctl0_w_r <= 1'b0;
         ctl1_w_r <= 1'b0;
         grp0_w_r <= 1'b0;
         grp1_w_r <= 1'b0;
      end else if (i_ce) begin
         ctl0_w_r <= ctl0_w_r | wr_ctl0;
         ctl1_w_r <= ctl1_w_r | wr_ctl1;
         grp0_w_r <= grp0_w_r | wr_grp0;
         grp1_w_r <= grp1_w_r | wr_grp1;
      end
   end

   // until written, fused registers read their fuse value
   assign ctl0_q = ctl0_w_r ? ctl0_r : ctl_rst0; // [RQ2]
   assign ctl1_q = ctl1_w_r ? ctl1_r : ctl_rst1; // [RQ2]
   assign grp0_q = grp0_w_r ? grp0_r : {2'h0, FUSE_GRP0}; // [RQ7] [RQ8]
   assign grp1_q = grp1_w_r ? grp1_r : {2'h0, FUSE_GRP1}; // [RQ7] [RQ8]

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = RST_ZERO;
      hit_nxt = 1'b1;
      case (i_addr)
         ADDR_VCODE0: rdata_nxt = vcode0_r;
         ADDR_VCODE1: rdata_nxt = vcode1_r;
         ADDR_CTL0: rdata_nxt = ctl0_q;
         ADDR_CTL1: rdata_nxt = ctl1_q;
         ADDR_RAMP0: rdata_nxt = ramp0_r;
         ADDR_RAMP1: rdata_nxt = ramp1_r;
         ADDR_GRP0: rdata_nxt = grp0_q;
         ADDR_GRP1: rdata_nxt = grp1_q;
         ADDR_DEFER: rdata_nxt = defer_r;
         default: hit_nxt = 1'b0;
      endcase
   end

   assign o_addr_hit = hit_nxt;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= RST_ZERO;
         o_rd_valid <= 1'b0;
      end else if (i_ce) begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en) o_rdata <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // platform reset detection
   // ------------------------------------------------------------
   logic rsm_n;
   logic plt_n;

   brc_sync #(.RESET_VAL(1'b1)) u_sync_rsm (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_async(i_resume_reset_n),
      .o_level(rsm_n)
   ); // [RQ14]

   brc_sync #(.RESET_VAL(1'b1)) u_sync_plt (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_async(i_platform_reset_n),
      .o_level(plt_n)
   ); // [RQ14]

   wire logic both_low = !rsm_n && !plt_n; // [RQ12] [RQ14]

   // sticky until system reset
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         released_r <= 1'b0;
      end else if (i_ce && both_low) begin
         released_r <= 1'b1; // [RQ13] [RQ14]
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   wire logic [1:0] type0_prog = grp0_q[GRP_TYPE_LO +: 2];
   wire logic [1:0] type1_prog = grp1_q[GRP_TYPE_LO +: 2];
   wire logic hold0 = defer_r[0] && !released_r; // [RQ11] [RQ12]
   wire logic hold1 = defer_r[1] && !released_r; // [RQ11] [RQ12]
   wire logic [1:0] type_a = BRC_TYPE_A;

   // [RQ10] [RQ11] [RQ13]
   wire logic [1:0] type0_nxt = hold0 ? type_a : type0_prog;
   wire logic [1:0] type1_nxt = hold1 ? type_a : type1_prog;

   // [RQ3] [RQ4]
   wire logic on0_nxt = ctl0_q[CTL_SEL_BIT] ? ctl0_q[CTL_CMD_BIT] :
                        i_seq_on[0];
   wire logic on1_nxt = ctl1_q[CTL_SEL_BIT] ? ctl1_q[CTL_CMD_BIT] :
                        i_seq_on[1];

   wire logic [3:0] gd0 = grp0_q[GRP_DELAY_LO +: 4];
   wire logic [3:0] gd1 = grp1_q[GRP_DELAY_LO +: 4];
   wire logic [1:0] fr0 = ramp0_r[RAMP_FAST_LO +: 2];
   wire logic [1:0] fr1 = ramp1_r[RAMP_FAST_LO +: 2];
   wire logic [1:0] slow_nxt = {ramp1_r[RAMP_SLOW_BIT],
                                ramp0_r[RAMP_SLOW_BIT]};
   wire logic [1:0] bad_nxt = {fr1 == FAST_RESERVED, fr0 == FAST_RESERVED};
   wire logic [1:0] excl_nxt = {gd1 == GROUP_DISABLE, gd0 == GROUP_DISABLE};

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_voltage_code_0 <= RST_VCODE;
         o_voltage_code_1 <= RST_VCODE;
         o_rail_on <= 2'h0;
         o_link_en <= 2'h0;
         o_fast_ramp_0 <= 2'h0;
         o_fast_ramp_1 <= 2'h0;
         o_slow_ramp <= 2'h0;
         o_fast_ramp_bad <= 2'h0;
         o_rail_type_0 <= 2'h0;
         o_rail_type_1 <= 2'h0;
         o_group_delay_0 <= 4'h0;
         o_group_delay_1 <= 4'h0;
         o_seq_excluded <= 2'h0;
         o_type_released <= 2'h0;
      end else if (i_ce && fuse_loaded_r) begin
         o_voltage_code_0 <= vcode0_r; // [RQ1]
         o_voltage_code_1 <= vcode1_r; // [RQ1]
         o_rail_on <= {on1_nxt, on0_nxt}; // [RQ3] [RQ4]
         o_link_en <= {ctl1_q[CTL_LINK_BIT], ctl0_q[CTL_LINK_BIT]}; // [RQ2]
         o_fast_ramp_0 <= fr0; // [RQ5]
         o_fast_ramp_1 <= fr1; // [RQ5]
         o_slow_ramp <= slow_nxt; // [RQ6]
         o_fast_ramp_bad <= bad_nxt; // [RQ5]
         o_rail_type_0 <= type0_nxt; // [RQ7] [RQ10] [RQ11] [RQ13]
         o_rail_type_1 <= type1_nxt; // [RQ7] [RQ10] [RQ11] [RQ13]
         o_group_delay_0 <= gd0; // [RQ8] [RQ11]
         o_group_delay_1 <= gd1; // [RQ8] [RQ11]
         o_seq_excluded <= excl_nxt; // [RQ8]
         o_type_released <= {!hold1, !hold0}; // [RQ13]
      end
   end
endmodule // brc_regs

// ---- verification/brc_regs_properties.sv ----
module brc_regs_checker
   import brc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_resume_reset_n,
   input wire logic i_platform_reset_n,
   input wire logic [7:0] o_rdata,
   input wire logic o_rd_valid,
   input wire logic o_addr_hit,
   input wire logic [7:0] o_voltage_code_0,
   input wire logic [1:0] o_rail_on,
   input wire logic [1:0] o_fast_ramp_0,
   input wire logic [1:0] o_fast_ramp_bad,
   input wire logic [1:0] o_rail_type_1,
   input wire logic [3:0] o_group_delay_0,
   input wire logic [1:0] o_seq_excluded
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // -------------------------------------------------------------
   // helper state: pins seen low together, rail 1 deferral written
   // -------------------------------------------------------------
   logic both_seen_r;
   logic defer1_r;
   wire logic take_rd = i_rd_en && i_ce;
   wire logic both_low = !i_resume_reset_n && !i_platform_reset_n;
   wire logic defer_wr = i_wr_en && i_ce && i_addr == ADDR_DEFER;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         both_seen_r <= 1'b0;
         defer1_r <= 1'b0;
      end else begin
         if (both_low)
            both_seen_r <= 1'b1;
         if (defer_wr)
            defer1_r <= i_wdata[1];
      end
   end
   AST_RD_VALID: assert property (take_rd |=> o_rd_valid)
      else $error("read not answered");
   AST_RD_IDLE: assert property (i_ce && !i_rd_en |=> !o_rd_valid)
      else $error("spurious read valid");
   AST_RD_UNMAPPED: assert property
      (take_rd && !o_addr_hit |=> o_rdata == RST_ZERO)
      else $error("unmapped read not zero");
   AST_VCODE_WR: assert property
      (i_wr_en && i_ce && i_addr == ADDR_VCODE0 ##1 i_ce
       |=> o_voltage_code_0 == $past(i_wdata, 2))
      else $error("voltage code not written");
   AST_FAST_BAD: assert property
      (o_fast_ramp_bad[0] == (o_fast_ramp_0 == FAST_RESERVED))
      else $error("reserved fast ramp flag wrong");
   AST_EXCLUDED: assert property
      (o_seq_excluded[0] == (o_group_delay_0 == GROUP_DISABLE))
      else $error("group disable flag wrong");
   AST_DEFER_A: assert property
      ($past(defer1_r) && defer1_r && !both_seen_r && $past(i_ce)
       |-> o_rail_type_1 == BRC_TYPE_A)
      else $error("deferred rail not type A");
   AST_RST_VAL: assert property ($rose(i_rst_b)
      |-> o_voltage_code_0 == RST_VCODE && o_rail_on == 2'h0)
      else $error("reset values wrong");
   AST_FREEZE: assert property (!i_ce
      |=> $stable(o_voltage_code_0) && $stable(o_rail_on))
      else $error("outputs moved while disabled");
   cover property (take_rd && !o_addr_hit);
   cover property (o_fast_ramp_bad[0]);
   cover property (both_low && defer1_r);
endmodule // brc_regs_checker

bind brc_regs brc_regs_checker i_chk (.i_clk, .i_rst_b, .i_ce, .i_wr_en,
   .i_rd_en, .i_addr, .i_wdata, .i_resume_reset_n, .i_platform_reset_n,
   .o_rdata, .o_rd_valid, .o_addr_hit, .o_voltage_code_0, .o_rail_on,
   .o_fast_ramp_0, .o_fast_ramp_bad, .o_rail_type_1, .o_group_delay_0,
   .o_seq_excluded);

// ---- verification/brc_plat_model.sv ----
module brc_plat_model (
   input wire logic i_clk,
   output logic o_resume_reset_n,
   output logic o_platform_reset_n,
   output logic [1:0] o_seq_on
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_resume_reset_n = 1'b1;
      o_platform_reset_n = 1'b1;
      o_seq_on = 2'h0;
   end
   task automatic set_seq(input logic [1:0] v);
      @(posedge i_clk);
      o_seq_on <= v;
   endtask
   // ---------------------------------------------------------
   // reset pins move off the clock edge, unrelated to the block
   // ---------------------------------------------------------
   task automatic pulse(input logic both);
      #2;
      o_resume_reset_n = 1'b0;
      o_platform_reset_n = !both;
      repeat (4) @(posedge i_clk);
      #2;
      o_resume_reset_n = 1'b1;
      o_platform_reset_n = 1'b0;
      repeat (4) @(posedge i_clk);
      #2;
      o_platform_reset_n = 1'b1;
   endtask
endmodule // brc_plat_model

// ---- verification/brc_regs_tb.sv ----
module brc_regs_tb;
   import brc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst_b, i_ce, i_wr_en, i_rd_en, o_rd_valid, o_addr_hit;
   logic rsm_n, plt_n;
   logic [7:0] i_addr, i_wdata, o_rdata, o_voltage_code_0, o_voltage_code_1;
   logic [7:0] d, v0;
   logic [1:0] seq_on, o_rail_on, o_link_en, o_fast_ramp_0, o_fast_ramp_1;
   logic [1:0] o_slow_ramp, o_fast_ramp_bad, o_rail_type_0, o_rail_type_1;
   logic [1:0] o_seq_excluded, o_type_released;
   logic [3:0] o_group_delay_0, o_group_delay_1;
   int miscompares = 0, num_checks = 0, seed = 73514;
   logic [7:0] adr [10] = '{8'h10, 8'h53, 8'h54, 8'ha8, 8'ha9, 8'hbe,
      8'hce, 8'he6, 8'he7, 8'h55};
   logic [7:0] rst [10] = '{8'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'h97,
      8'h97, 8'h00, 8'h25, 8'h00};
   brc_regs #(.FUSE_GRP0(6'h00), .FUSE_GRP1(6'h25)) i_dut (.i_clk, .i_rst_b,
      .i_ce, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_valid,
      .o_addr_hit, .i_seq_on(seq_on), .i_resume_reset_n(rsm_n),
      .i_platform_reset_n(plt_n), .o_voltage_code_0, .o_voltage_code_1,
      .o_rail_on, .o_link_en, .o_fast_ramp_0, .o_fast_ramp_1, .o_slow_ramp,
      .o_fast_ramp_bad, .o_rail_type_0, .o_rail_type_1, .o_group_delay_0,
      .o_group_delay_1, .o_seq_excluded, .o_type_released);
   brc_plat_model i_plat (.i_clk, .o_resume_reset_n(rsm_n),
      .o_platform_reset_n(plt_n), .o_seq_on(seq_on));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   // ------------------------------------------
   // bus tasks, compare, expectations, closing
   // ------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      chk({7'h0, o_rd_valid}, 8'h01);
      chk(o_rdata, exp);
      chk({7'h0, o_addr_hit}, {7'h0, wmask(a) != 8'h00});
   endtask
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h10: return 8'h03;
         8'h53, 8'h54: return 8'h13;
         8'ha8, 8'ha9: return 8'h31;
         8'he6, 8'he7: return 8'h3f;
         8'hbe, 8'hce: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      miscompares++;
      wrap_up;
   end
   initial begin
      {i_rst_b, i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
      i_ce = 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 10; i++) rd(adr[i], rst[i]);
      chk({6'h0, o_link_en}, 8'h03);
      done("reset");
      for (int i = 0; i < 10; i++) begin
         d = 8'($random(seed));
         wr(adr[i], d);
         if (i == 5) v0 = d;
         if (i == 5) chk(o_voltage_code_0, d);
         if (i == 6) chk(o_voltage_code_1, d);
         rd(adr[i], d & wmask(adr[i]));
      end
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(ADDR_VCODE0, ~v0);
      chk(o_voltage_code_0, v0);
      i_ce <= 1'b1;
      rd(ADDR_VCODE0, v0);
      done("random");
      for (int k = 0; k < 16; k++) begin
         i_plat.set_seq(k[2] ? 2'h3 : 2'h0);
         wr(k[3] ? ADDR_CTL1 : ADDR_CTL0, {3'h0, k[0], 2'h0, k[1], k[0]});
         chk({7'h0, o_rail_on[k[3]]}, {7'h0, k[1] ? k[0] : k[2]});
         chk({7'h0, o_link_en[k[3]]}, {7'h0, k[0]});
      end
      done("onoff");
      wr(ADDR_DEFER, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_RAMP0, {2'h0, k[1:0], 3'h0, k[0]});
         wr(ADDR_RAMP1, {2'h0, k[1:0], 3'h0, k[0]});
         wr(ADDR_GRP0, {2'h0, k[1:0], k[1:0], k[1:0]});
         wr(ADDR_GRP1, {2'h0, k[1:0], k[1:0], k[1:0]});
         chk({6'h0, o_fast_ramp_0}, {6'h0, k[1:0]});
         chk({6'h0, o_fast_ramp_1}, {6'h0, k[1:0]});
         chk({6'h0, o_fast_ramp_bad}, {6'h0, {2{k == 3}}});
         chk({6'h0, o_slow_ramp}, {6'h0, {2{k[0]}}});
         chk({6'h0, o_rail_type_0}, {6'h0, k[1:0]});
         chk({6'h0, o_rail_type_1}, {6'h0, k[1:0]});
         chk({4'h0, o_group_delay_0}, {4'h0, k[1:0], k[1:0]});
         chk({4'h0, o_group_delay_1}, {4'h0, k[1:0], k[1:0]});
         chk({6'h0, o_seq_excluded}, {6'h0, {2{k == 3}}});
      end
      done("fields");
      wr(ADDR_GRP1, 8'h25);
      wr(ADDR_DEFER, 8'h02);
      chk({6'h0, o_rail_type_1}, 8'h00);
      chk({4'h0, o_group_delay_1}, 8'h05);
      chk({6'h0, o_type_released}, 8'h01);
      i_plat.pulse(1'b0);
      repeat (8) @(posedge i_clk);
      #1;
      chk({6'h0, o_rail_type_1}, 8'h00);
      chk({6'h0, o_type_released}, 8'h01);
      i_plat.pulse(1'b1);
      for (int n = 0; n < 20 && o_type_released[1] !== 1'b1; n++)
         @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      #1;
      chk({6'h0, o_rail_type_1}, 8'h02);
      chk({6'h0, o_type_released}, 8'h03);
      wr(ADDR_GRP1, 8'h35);
      chk({6'h0, o_rail_type_1}, 8'h03);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      wr(ADDR_DEFER, 8'h02);
      chk({6'h0, o_rail_type_1}, 8'h00);
      done("deferred");
      wrap_up;
   end
endmodule // brc_regs_tb
